/* tb/tb_reset_option_config.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  num_errors++; $display("Error %s exp %h got %h", nm, ex, gt); end end
module tb_reset_option_config;
  import roc_pkg::*;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  s_awaddr = 0, s_araddr = 0;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0;
  logic        s_arvalid = 0, s_rready = 0;
  logic [31:0] s_wdata = 0, s_rdata;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, vmon0_level_sel;
  logic [31:0] w_wdog = 0, w_pow = 0, w_ord = 0, old_wdog;
  logic [8:0]  src = 0;
  logic [4:0]  lp = 0;
  logic [13:0] wdog_reload;
  logic [3:0]  wdog_div_shift;
  logic        wdog_div_rsvd, wdog_count_stop, fast_startup, userboot_ok;
  logic        cfg_valid, sw_reset_req, stp;
  logic        boot_um = 0;
  logic [31:0] w_ub = 0;
  logic [1:0]  be;
  logic [2:0]  byte_order;
  logic [31:0] rng = 32'h0000_0043;
  logic [33:0] re;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          num_errors = 0, total_checks = 0, swp = 0, s0;
  logic [3:0]  ckt[7] = '{CKS_X1, CKS_X16, CKS_X32, CKS_X64, CKS_X128,
                          CKS_X256, 4'h1};
  logic [3:0]  sht[7] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h0};
  logic [13:0] rlt[4] = '{14'h007f, 14'h01ff, 14'h03ff, 14'h07ff};

  roc_top #(.ALT(1'b0), .ADDR_W(8)) dut (.aclk, .aresetn, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .nvm_wdog_word(w_wdog),
    .nvm_power_word(w_pow), .nvm_order_word(w_ord), .nvm_order_ub(w_ub),
    .nvm_ub_code_a(32'h0), .nvm_ub_code_b(32'h0), .boot_user_mode(boot_um),
    .ext_reset_pin(src[CAUSE_EXT]), .src_power_on(src[CAUSE_POR]),
    .src_vmon0(src[CAUSE_VM0]), .src_vmon1(src[CAUSE_VM1]),
    .src_vmon2(src[CAUSE_VM2]), .src_deep_standby(src[CAUSE_DEEP]),
    .src_independent_watchdog(src[CAUSE_INDEP]),
    .src_watchdog(src[CAUSE_WDT]), .src_software(src[CAUSE_SW]),
    .lp_sleep(lp[0]), .lp_sw_standby(lp[1]), .lp_deep_sleep(lp[2]),
    .lp_deep_standby(lp[3]), .lp_all_clk_stop(lp[4]), .wdog_reload,
    .wdog_div_shift, .wdog_div_rsvd, .wdog_count_stop, .vmon0_level_sel,
    .fast_startup, .byte_order, .userboot_ok, .cfg_valid, .sw_reset_req);

  always #20 aclk = ~aclk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    bq.push_back(er);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1;
    s_wvalid <= 1;
    s_bready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 0;
      if (s_wready) s_wvalid <= 0;
      n++;
    end while (s_bvalid !== 1'b1 && n < 100);
    s_bready <= 0;
    if (n >= 100) begin num_errors++; summarize(); end
  endtask : axw

  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    rq.push_back({er, d});
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 0;
      n++;
    end while (s_rvalid !== 1'b1 && n < 100);
    s_rready <= 0;
    if (n >= 100) begin num_errors++; summarize(); end
  endtask : axr

  task rst(input int n);
    @(posedge aclk);
    aresetn <= 0;
    repeat (n) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
  endtask : rst

  // answer monitor, oldest note first
  always @(posedge aclk) begin
    if (s_rvalid && s_rready) begin
      re = rq.pop_front();
      `CHK("rdata", re[31:0], s_rdata)
      `CHK("rresp", re[33:32], s_rresp)
    end
    if (s_bvalid && s_bready) begin
      be = bq.pop_front();
      `CHK("bresp", be, s_bresp)
    end
    if (sw_reset_req === 1'b1) swp++;
  end

  initial begin
    for (int i = 0; i < 7; i++) begin
      rng = xs(rng);
      w_pow <= rng;
      rng = xs(rng);
      w_ord <= rng;
      lp <= rng[4:0];
      boot_um <= rng[5];
      w_ub <= ~rng;
      w_wdog <= {rng[31:15], i[0], rng[13:8], ckt[i], i[1:0], rng[1:0]};
      rst(i == 0 ? 11 : 2);
      stp = i[0] & (lp[0] | lp[1] | lp[2]);
      `CHK("reload", rlt[i[1:0]], wdog_reload)
      `CHK("shift", sht[i], wdog_div_shift)
      `CHK("rsvd", i == 6, wdog_div_rsvd)
      `CHK("stop", stp, wdog_count_stop)
      `CHK("level", w_pow[1:0], vmon0_level_sel)
      `CHK("fast", w_pow[8], fast_startup)
      `CHK("order", w_ord[2:0], byte_order)
      `CHK("valid", 1'b1, cfg_valid)
      `CHK("ubok", 1'b0, userboot_ok)
      axr(OFF_WDOG, w_wdog, RESP_OKAY);
      $display("decode test %0d done", i);
    end
    // words held while memory changes
    old_wdog = w_wdog;
    w_wdog <= ~w_wdog;
    axw(OFF_WDOG, 32'h0, RESP_OKAY);
    axr(OFF_WDOG, old_wdog, RESP_OKAY);
    axr(OFF_POWER, w_pow, RESP_OKAY);
    axr(OFF_ORDER, w_ord, RESP_OKAY);
    axr(OFF_ORDER_UB, 32'h0, RESP_OKAY);
    axr(8'h24, 32'h0, RESP_SLVERR);
    axw(8'h26, 32'h1, RESP_SLVERR);
    `CHK("held", rlt[old_wdog[3:2]], wdog_reload)
    $display("hold test done");
    for (int k = 0; k < 9; k++) begin
      @(posedge aclk);
      src[k] <= 1;
      repeat (6) @(posedge aclk);
      src[k] <= 0;
      repeat (3) @(posedge aclk);
    end
    axr(OFF_CAUSE, 32'hef, RESP_OKAY);
    axr(OFF_STATUS, 32'h15, RESP_OKAY);
    // clear without byte 0 strobe is ignored
    s_wstrb <= 4'he;
    axw(OFF_CAUSE, 32'hff, RESP_OKAY);
    axr(OFF_CAUSE, 32'hef, RESP_OKAY);
    s_wstrb <= 4'hf;
    axw(OFF_CAUSE, 32'hff, RESP_OKAY);
    axw(OFF_STATUS, 32'h10, RESP_OKAY);
    axr(OFF_CAUSE, 32'h0, RESP_OKAY);
    axr(OFF_STATUS, 32'h5, RESP_OKAY);
    s0 = swp;
    axw(OFF_CTRL, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("swreq", 1, swp - s0)
    $display("reset cause test done");
    summarize();
  end
endmodule : tb_reset_option_config

/* verilog/roc_pkg.sv */
package roc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_WDOG     = 8'h00;
  localparam logic [7:0] OFF_POWER    = 8'h04;
  localparam logic [7:0] OFF_ORDER    = 8'h08;
  localparam logic [7:0] OFF_ORDER_UB = 8'h0c;
  localparam logic [7:0] OFF_CAUSE    = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_CTRL     = 8'h18;
  localparam logic [7:0] OFF_UB_A     = 8'h1c;
  localparam logic [7:0] OFF_UB_B     = 8'h20;
  // option word field positions
  localparam int TOPS_LSB   = 2;
  localparam int CKS_LSB    = 4;
  localparam int SLCSTP_BIT = 14;
  localparam int VMON0_LSB  = 0;
  localparam int FAST_BIT   = 8;
  localparam int ORDER_LSB  = 0;
  // reset source bit positions and source count; cause register keeps bits 0 to 7
  localparam int CAUSE_POR   = 0;
  localparam int CAUSE_VM0   = 1;
  localparam int CAUSE_VM1   = 2;
  localparam int CAUSE_VM2   = 3;
  localparam int CAUSE_DEEP  = 4;
  localparam int CAUSE_EXT   = 5;
  localparam int CAUSE_INDEP = 6;
  localparam int CAUSE_WDT   = 7;
  localparam int CAUSE_SW    = 8;
  localparam int N_SRC       = 9;
  // status and control bit positions
  localparam int ST_VALID    = 0;
  localparam int ST_UB_OK    = 1;
  localparam int ST_DIV_RSVD = 2;
  localparam int ST_ALT      = 3;
  localparam int ST_SW_FLAG  = 4;
  localparam int ST_STOP     = 5;
  localparam int CTRL_SW_REQ = 0;
  // reset values
  localparam logic [7:0]  CAUSE_RST = 8'h00;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  // watchdog reload values, primary then alternate
  localparam logic [13:0] RLD_P0 = 14'h007f;
  localparam logic [13:0] RLD_P1 = 14'h01ff;
  localparam logic [13:0] RLD_P2 = 14'h03ff;
  localparam logic [13:0] RLD_P3 = 14'h07ff;
  localparam logic [13:0] RLD_A0 = 14'h03ff;
  localparam logic [13:0] RLD_A1 = 14'h0fff;
  localparam logic [13:0] RLD_A2 = 14'h1fff;
  localparam logic [13:0] RLD_A3 = 14'h3fff;
  // divide codes, named by divide ratio; shift amounts decoded in roc_wdog_decode
  localparam logic [3:0] CKS_X1   = 4'h0;
  localparam logic [3:0] CKS_X16  = 4'h2;
  localparam logic [3:0] CKS_X32  = 4'h3;
  localparam logic [3:0] CKS_X64  = 4'h4;
  localparam logic [3:0] CKS_X128 = 4'hf;
  localparam logic [3:0] CKS_X256 = 4'h5;
  // user boot keys, values arbitrary
  localparam logic [31:0] UB_KEY_A = 32'h1234_5678;
  localparam logic [31:0] UB_KEY_B = 32'h9abc_def0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ROC_ST_LOAD, ROC_ST_HELD} roc_state_e;
endpackage : roc_pkg

/* verilog/roc_top.sv */
`timescale 1ns/1ns
module roc_top #(
  parameter bit ALT    = 1'b0, // 0 primary, 1 alternate
  parameter int ADDR_W = 8     // axi address width
) (
  input  wire logic              aclk,            // system clock 25 MHz
  input  wire logic              aresetn,         // sync reset, low
  input  wire logic [ADDR_W-1:0] s_awaddr,        // write address
  input  wire logic              s_awvalid,       // write addr valid
  output logic                   s_awready,       // write addr ready
  input  wire logic [31:0]       s_wdata,         // write data
  input  wire logic [3:0]        s_wstrb,         // write strobes
  input  wire logic              s_wvalid,        // write data valid
  output logic                   s_wready,        // write data ready
  output logic      [1:0]        s_bresp,         // write response
  output logic                   s_bvalid,        // write resp valid
  input  wire logic              s_bready,        // write resp ready
  input  wire logic [ADDR_W-1:0] s_araddr,        // read address
  input  wire logic              s_arvalid,       // read addr valid
  output logic                   s_arready,       // read addr ready
  output logic      [31:0]       s_rdata,         // read data
  output logic      [1:0]        s_rresp,         // read response
  output logic                   s_rvalid,        // read data valid
  input  wire logic              s_rready,        // read data ready
  input  wire logic [31:0]       nvm_wdog_word,   // option memory word
  input  wire logic [31:0]       nvm_power_word,  // option memory word
  input  wire logic [31:0]       nvm_order_word,  // option memory word
  input  wire logic [31:0]       nvm_order_ub,    // user-boot copy
  input  wire logic [31:0]       nvm_ub_code_a,   // user boot code a
  input  wire logic [31:0]       nvm_ub_code_b,   // user boot code b
  input  wire logic              boot_user_mode,  // user boot selected
  input  wire logic              ext_reset_pin,   // pin reset seen
  input  wire logic              src_power_on,    // power-on reset
  input  wire logic              src_vmon0,       // monitor 0 reset
  input  wire logic              src_vmon1,       // monitor 1 reset
  input  wire logic              src_vmon2,       // monitor 2 reset
  input  wire logic              src_deep_standby,// deep standby return
  input  wire logic              src_independent_watchdog, // indep wdog
  input  wire logic              src_watchdog,    // wdt reset
  input  wire logic              src_software,    // software reset
  input  wire logic              lp_sleep,        // sleep mode
  input  wire logic              lp_sw_standby,   // software standby
  input  wire logic              lp_deep_sleep,   // deep sleep
  input  wire logic              lp_deep_standby, // deep sw standby
  input  wire logic              lp_all_clk_stop, // all clock stop
  output logic      [13:0]       wdog_reload,     // timeout reload
  output logic      [3:0]        wdog_div_shift,  // log2 divide ratio
  output logic                   wdog_div_rsvd,   // reserved divide
  output logic                   wdog_count_stop, // count halted
  output logic      [1:0]        vmon0_level_sel, // monitor 0 level
  output logic                   fast_startup,    // fast startup
  output logic      [2:0]        byte_order,      // data byte order
  output logic                   userboot_ok,     // user boot allowed
  output logic                   cfg_valid,       // words held
  output logic                   sw_reset_req     // sw reset pulse
);
  import roc_pkg::*;

  if (ADDR_W < 6 || ADDR_W > 32) begin : g_addr_w_chk
    $error("ADDR_W out of range");
  end

  // word aligned, inside the map, no high bits
  function automatic logic map_ok(input logic [31:0] a);
    map_ok = (a[31:8] == 24'h0) && (a[1:0] == 2'h0) &&
             (a[7:0] <= OFF_UB_B);
  endfunction : map_ok

  roc_state_e  state_ff;
  logic [31:0] wdog_word_ff, power_word_ff, order_word_ff, order_ub_ff;
  logic [31:0] ub_a_ff, ub_b_ff;
  logic [1:0]  vmon0_ff;
  logic        fast_ff, ub_ok_ff, sw_req_ff, valid_ff;
  logic [2:0]  order_ff;
  logic [N_SRC-1:0] src_meta_ff, src_sync_ff, src_prev_ff;
  logic [7:0]  cause_ff;
  logic        sw_flag_ff;

  wire logic held = (state_ff == ROC_ST_HELD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff      <= ROC_ST_LOAD;
      valid_ff      <= 1'b0;
      wdog_word_ff  <= WORD_RST;
      power_word_ff <= WORD_RST;
      order_word_ff <= WORD_RST;
      order_ub_ff   <= WORD_RST;
      ub_a_ff       <= WORD_RST;
      ub_b_ff       <= WORD_RST;
    end else if (!held) begin
      state_ff      <= ROC_ST_HELD;
      valid_ff      <= 1'b1;
      wdog_word_ff  <= nvm_wdog_word;
      power_word_ff <= ALT ? WORD_RST : nvm_power_word;
      order_word_ff <= nvm_order_word;
      order_ub_ff   <= ALT ? nvm_order_ub : WORD_RST;
      ub_a_ff       <= ALT ? nvm_ub_code_a : WORD_RST;
      ub_b_ff       <= ALT ? nvm_ub_code_b : WORD_RST;
    end
  end

  wire logic [1:0] nxt_vmon0 = ALT ? 2'h0 : power_word_ff[VMON0_LSB +: 2];
  wire logic       nxt_fast  = !ALT && power_word_ff[FAST_BIT];
  wire logic [2:0] nxt_order = (ALT && boot_user_mode) ?
                               order_ub_ff[ORDER_LSB +: 3] :
                               order_word_ff[ORDER_LSB +: 3];
  wire logic nxt_ub_ok = ALT && held && (ub_a_ff == UB_KEY_A) &&
                         (ub_b_ff == UB_KEY_B);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vmon0_ff <= 2'h0;
      fast_ff  <= 1'b0;
      order_ff <= 3'h0;
      ub_ok_ff <= 1'b0;
    end else begin
      vmon0_ff <= nxt_vmon0;
      fast_ff  <= nxt_fast;
      order_ff <= nxt_order;
      ub_ok_ff <= nxt_ub_ok;
    end
  end

  roc_wdog_decode #(.ALT(ALT)) u_wdog (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .cfg_valid       (held),
    .wdog_word       (wdog_word_ff),
    .lp_sleep        (lp_sleep),
    .lp_sw_standby   (lp_sw_standby),
    .lp_deep_sleep   (lp_deep_sleep),
    .lp_deep_standby (lp_deep_standby),
    .lp_all_clk_stop (lp_all_clk_stop),
    .reload_ff       (wdog_reload),
    .div_shift_ff    (wdog_div_shift),
    .div_rsvd_ff     (wdog_div_rsvd),
    .count_stop_ff   (wdog_count_stop)
  );

  // reset cause inputs come from other domains
  wire logic [N_SRC-1:0] src_raw = {src_software, src_watchdog,
    src_independent_watchdog, ext_reset_pin, src_deep_standby,
    src_vmon2, src_vmon1, src_vmon0, src_power_on};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_meta_ff <= '0;
      src_sync_ff <= '0;
      src_prev_ff <= '0;
    end else begin
      src_meta_ff <= src_raw;
      src_sync_ff <= src_meta_ff;
      src_prev_ff <= src_sync_ff;
    end
  end
  wire logic [N_SRC-1:0] src_rise = src_sync_ff & ~src_prev_ff;

  // axi write channel
  logic              awready_ff, wready_ff, bvalid_ff, aw_got_ff, w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic [1:0]        bresp_ff;
  wire logic aw_hs  = s_awvalid && awready_ff;
  wire logic w_hs   = s_wvalid && wready_ff;
  wire logic wr_go  = aw_got_ff && w_got_ff && !bvalid_ff;
  wire logic b_done = bvalid_ff && s_bready;
  wire logic [31:0] wa_w = 32'(awaddr_ff);
  wire logic [7:0]  wa = wa_w[7:0];
  wire logic wa_hi_ok = (wa_w[31:8] == 24'h0);
  wire logic wr_map = map_ok(wa_w);
  wire logic wr_cause  = wr_go && wa_hi_ok && wa == OFF_CAUSE && wstrb_ff[0];
  wire logic wr_status = wr_go && wa_hi_ok && wa == OFF_STATUS &&
                         wstrb_ff[0];
  wire logic wr_ctrl   = wr_go && wa_hi_ok && wa == OFF_CTRL && wstrb_ff[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
    end else begin
      awready_ff <= !aw_got_ff && !aw_hs && !bvalid_ff && !wr_go;
      wready_ff  <= !w_got_ff && !w_hs && !bvalid_ff && !wr_go;
      if (aw_hs) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_awaddr;
      end else if (wr_go) begin
        aw_got_ff <= 1'b0;
      end
      if (w_hs) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end else if (wr_go) begin
        w_got_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  wire logic [7:0] cause_set = src_rise[7:0] &
                               ~(ALT ? 8'h00 : 8'h10);
  wire logic [7:0] cause_clr = wr_cause ? wdata_ff[7:0] : 8'h00;
  wire logic       sw_clr    = wr_status && wdata_ff[ST_SW_FLAG];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_ff   <= CAUSE_RST;
      sw_flag_ff <= 1'b0;
      sw_req_ff  <= 1'b0;
    end else begin
      cause_ff   <= (cause_ff & ~cause_clr) | cause_set;
      sw_flag_ff <= (sw_flag_ff && !sw_clr) || src_rise[CAUSE_SW];
      sw_req_ff  <= wr_ctrl && wdata_ff[CTRL_SW_REQ];
    end
  end

  // axi read channel
  logic        arready_ff, rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  wire logic ar_hs = s_arvalid && arready_ff;
  wire logic [31:0] ra_w = 32'(s_araddr);
  wire logic [7:0]  ra = ra_w[7:0];
  wire logic ra_ok = map_ok(ra_w);
  wire logic [31:0] status_word = {26'h0, wdog_count_stop, sw_flag_ff,
                                   ALT, wdog_div_rsvd, ub_ok_ff, held};
  wire logic [31:0] rd_mux =
    !ra_ok             ? 32'h0 :
    ra == OFF_WDOG     ? wdog_word_ff :
    ra == OFF_POWER    ? power_word_ff :
    ra == OFF_ORDER    ? order_word_ff :
    ra == OFF_ORDER_UB ? order_ub_ff :
    ra == OFF_CAUSE    ? {24'h0, cause_ff} :
    ra == OFF_STATUS   ? status_word :
    ra == OFF_UB_A     ? ub_a_ff :
    ra == OFF_UB_B     ? ub_b_ff : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= !rvalid_ff && !ar_hs;
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mux;
        rresp_ff  <= ra_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_awready       = awready_ff;
  assign s_wready        = wready_ff;
  assign s_bvalid        = bvalid_ff;
  assign s_bresp         = bresp_ff;
  assign s_arready       = arready_ff;
  assign s_rvalid        = rvalid_ff;
  assign s_rdata         = rdata_ff;
  assign s_rresp         = rresp_ff;
  assign vmon0_level_sel = vmon0_ff;
  assign fast_startup    = fast_ff;
  assign byte_order      = order_ff;
  assign userboot_ok     = ub_ok_ff;
  assign cfg_valid       = valid_ff;
  assign sw_reset_req    = sw_req_ff;

  word_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    held |=> held && $stable(wdog_word_ff) && $stable(order_word_ff))
    else $error("option words changed while held");
  load_once_a: assert property (@(posedge aclk)
    !aresetn ##1 aresetn |=> cfg_valid)
    else $error("option words not latched one edge after release");
  cause_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    src_rise[CAUSE_EXT] |=> cause_ff[CAUSE_EXT])
    else $error("pin reset cause lost");
  deep_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ALT |-> !cause_ff[CAUSE_DEEP])
    else $error("deep standby flag set in primary variant");
  power_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    held ##1 held |-> vmon0_level_sel == (ALT ? 2'h0 :
      $past(power_word_ff[VMON0_LSB +: 2])) &&
      fast_startup == (!ALT && $past(power_word_ff[FAST_BIT])))
    else $error("power word fields mis-driven");
  order_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ALT || !boot_user_mode) |=> byte_order ==
      $past(order_word_ff[ORDER_LSB +: 3]))
    else $error("byte order from wrong word");
  ub_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    userboot_ok |-> ALT && ub_a_ff == UB_KEY_A && ub_b_ff == UB_KEY_B)
    else $error("user boot allowed without matching codes");
  bresp_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_bvalid and (!s_bready |=> s_bvalid))
    else $error("write response dropped before bready");
  rd_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs |=> s_rvalid && !s_arready)
    else $error("read not answered one edge after address");
  wr_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_cause ##[1:4] b_done);
  rd_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    ar_hs ##1 s_rvalid && s_rready);
  clr_set_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_cause && (cause_set & cause_clr) != 8'h00);
endmodule : roc_top

/* verilog/roc_wdog_decode.sv */
`timescale 1ns/1ns
module roc_wdog_decode #(
  parameter bit ALT = 1'b0
) (
  input  wire logic        aclk,            // system clock
  input  wire logic        aresetn,         // sync reset, low
  input  wire logic        cfg_valid,       // option words held
  input  wire logic [31:0] wdog_word,       // latched watchdog word
  input  wire logic        lp_sleep,        // sleep mode
  input  wire logic        lp_sw_standby,   // software standby
  input  wire logic        lp_deep_sleep,   // deep sleep
  input  wire logic        lp_deep_standby, // deep software standby
  input  wire logic        lp_all_clk_stop, // all-module clock stop
  output logic      [13:0] reload_ff,       // timeout reload value
  output logic      [3:0]  div_shift_ff,    // log2 of divide ratio
  output logic             div_rsvd_ff,     // reserved divide code
  output logic             count_stop_ff    // watchdog count halted
);
  import roc_pkg::*;

  function automatic logic [13:0] reload_of(input logic [1:0] sel);
    case (sel)
      2'h0:    reload_of = ALT ? RLD_A0 : RLD_P0;
      2'h1:    reload_of = ALT ? RLD_A1 : RLD_P1;
      2'h2:    reload_of = ALT ? RLD_A2 : RLD_P2;
      default: reload_of = ALT ? RLD_A3 : RLD_P3;
    endcase
  endfunction : reload_of

  wire logic [1:0] tops   = wdog_word[TOPS_LSB +: 2];
  wire logic [3:0] cks    = wdog_word[CKS_LSB +: 4];
  wire logic       slcstp = wdog_word[SLCSTP_BIT];
  wire logic       cks_ok = (cks == CKS_X1) || (cks == CKS_X16) ||
                            (cks == CKS_X32) || (cks == CKS_X64) ||
                            (cks == CKS_X128) || (cks == CKS_X256);
  wire logic [3:0] shift  = (cks == CKS_X16)  ? 4'h4 :
                            (cks == CKS_X32)  ? 4'h5 :
                            (cks == CKS_X64)  ? 4'h6 :
                            (cks == CKS_X128) ? 4'h7 :
                            (cks == CKS_X256) ? 4'h8 : 4'h0;
  wire logic lp_any = lp_sleep || lp_sw_standby ||
                      (ALT ? (lp_deep_standby || lp_all_clk_stop)
                           : lp_deep_sleep);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_ff     <= RLD_P0;
      div_shift_ff  <= 4'h0;
      div_rsvd_ff   <= 1'b0;
      count_stop_ff <= 1'b0;
    end else begin
      reload_ff     <= reload_of(tops);
      div_shift_ff  <= shift;
      div_rsvd_ff   <= cfg_valid && !cks_ok;
      count_stop_ff <= cfg_valid && slcstp && lp_any;
    end
  end

  timing_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 1'b1 |-> reload_ff == reload_of($past(tops)))
    else $error("reload value does not follow timeout select");
  div_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cks == CKS_X256) ##1 1'b1 |-> div_shift_ff == 4'h8 && !div_rsvd_ff)
    else $error("divide x256 mis-decoded");
  lp_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg_valid && !slcstp) |=> !count_stop_ff)
    else $error("count stopped although stop bit clear");
  rsvd_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg_valid && cks == 4'h1) |=> div_rsvd_ff)
    else $error("reserved divide code not flagged");
  stop_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    count_stop_ff);
endmodule : roc_wdog_decode
